// ---- src/cpp_pkg.sv ----
package cpp_pkg;

    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    localparam logic [31:0] SYNC_WORD = 32'h01332d94;
    localparam int WORD_W = 32;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // Header layout
    // ------------------------------------------------------------
    localparam int HDR_TYPE_HI = 31;
    localparam int HDR_TYPE_LO = 29;
    localparam int HDR_OP_HI = 28;
    localparam int HDR_OP_LO = 27;
    localparam int HDR_ADDR_HI = 26;
    localparam int HDR_ADDR_LO = 22;
    localparam int HDR1_CNT_HI = 21;
    localparam int HDR2_CNT_HI = 26;
    localparam logic [2:0] HDR_TYPE1 = 3'h5;
    localparam logic [2:0] HDR_TYPE2 = 3'h2;
    localparam logic [1:0] OP_NOP = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam int ID_CMP_BITS = 28;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [4:0] REG_CRC_CHECK = 5'h00;
    localparam logic [4:0] REG_DEVICE_ID_CHECK = 5'h01;
    localparam logic [4:0] REG_COMMAND = 5'h02;
    localparam logic [4:0] REG_CONTROL_ZERO = 5'h03;
    localparam logic [4:0] REG_CONTROL_ONE = 5'h04;
    localparam logic [4:0] REG_FRAME_DATA_IN = 5'h05;
    localparam logic [4:0] REG_MULTI_FRAME_WRITE = 5'h06;
    localparam logic [4:0] REG_FRAME_DATA_OUT = 5'h07;
    localparam logic [4:0] REG_INITIAL_VECTOR = 5'h08;
    localparam logic [4:0] REG_CONFIG_STATUS = 5'h09;
    localparam logic [4:0] REG_CASCADE_CONTROL = 5'h0a;
    localparam logic [4:0] REG_FRAME_ADDRESS = 5'h0b;
    localparam logic [4:0] REG_INTERNAL_BUS_PORT = 5'h0c;
    localparam logic [4:0] REG_UPSET_CONTROL = 5'h0d;
    localparam logic [4:0] REG_UPSET_STATUS = 5'h0e;
    localparam logic [4:0] REG_WARMBOOT_CONTROL = 5'h0f;
    localparam logic [4:0] REG_WARMBOOT_ADDRESS = 5'h10;
    localparam logic [4:0] REG_WATCHDOG_STATE = 5'h11;
    localparam logic [4:0] REG_HISTORY_STATUS = 5'h12;
    localparam logic [4:0] REG_CONTROL_MASK = 5'h17;
    localparam logic [4:0] REG_OPTION_ZERO = 5'h19;
    localparam logic [4:0] REG_OPTION_ONE = 5'h1a;
    localparam logic [4:0] REG_UPSET_FRAME_ADDRESS = 5'h1d;
    localparam logic [4:0] REG_UPSET_NEXT_FRAME_ADDRESS = 5'h1f;

    // Access classes per address: bit n of REG_READABLE readable, bit n of REG_WRITABLE writable
    localparam logic [31:0] REG_READABLE = 32'ha687fa9f;
    localparam logic [31:0] REG_WRITABLE = 32'h0683bd7f;

    // ------------------------------------------------------------
    // Commands and reset values
    // ------------------------------------------------------------
    localparam logic [4:0] CMD_NO_OPERATION = 5'h00;
    localparam logic [4:0] CMD_CLEAR_CRC = 5'h01;
    localparam logic [31:0] CRC_RESET = 32'h00000000;
    localparam logic [31:0] CRC_POLY = 32'h1edc6f41;
    localparam logic [31:0] REG_RESET = 32'h00000000;

    // ------------------------------------------------------------
    // Bus width selector
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CPP_W2 = 3'h0,
        CPP_W4 = 3'h1,
        CPP_W8 = 3'h2,
        CPP_W16 = 3'h3,
        CPP_W32 = 3'h4
    } cpp_width_t;

    // Register access seen by the frame memory port
    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] addr;
        logic [31:0] data;
    } cpp_access_t;

endpackage

// ---- src/cpp_fifo.sv ----
`timescale 1ns/10ps
module cpp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic doWrite;
    logic doRead;

    assign inReady = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData = mem_q[rdPtr_q];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    always_ff @(posedge mclk) begin
        if (doWrite) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doWrite) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (doRead) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(doWrite) - (AW+1)'(doRead);
        end
    end
endmodule

// ---- src/cpp_parser.sv ----
`timescale 1ns/10ps
// What this block does
// - Each 32-bit word arrives most significant part first on every width
// - Bus bit mapping depends only on selected width, never on mode
// - Word takes 16, 8, 4, 2 or 1 beats for widths 2..32
// - Type 1 packets access registers: header plus zero or more data words
// - Type 1 header: type 101, op [28:27], address [26:22], count [21:0]
// - Op code 00 no-op, 01 write, 10 read, 11 reserved
// - Zero-count type 1 header is empty; next word is a header
// - Type 2 header: type 010, op [28:27], count [26:0]
// - Type 2 follows an empty type 1 and reuses its address
// - Type 2 moves long bursts through the addressed frame data register
// - Five-bit address decoded against map from 00000 to 11111
// - Frame in, multi-frame, initial vector, cascade registers are write only
// - Frame out and status style registers are read only
// - Writes to CRC register compare with running CRC; mismatch drops done
// - Source writes identity first; all but identity, CRC and command registers blocked until it matches
// - Identity check compares low 28 bits; mismatch drops done flag
// - Command register holds five-bit code; 00001 clears running CRC
module cpp_parser #(
    parameter logic [31:0] DEVICE_ID = 32'h0abcdef1 // Arbitrary value
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Configuration data bus (pins)
    input wire cpp_pkg::cpp_width_t busWidth,
    input wire logic busValid,
    input wire logic [31:0] busData,
    output logic busReady,
    // Readback words
    output logic rdValid,
    output logic [31:0] rdData,
    // Frame memory port
    output cpp_pkg::cpp_access_t memAccess,
    input wire logic [31:0] frameDataOut,
    input wire logic [31:0] configStatus,
    input wire logic [31:0] upsetStatus,
    input wire logic [31:0] historyStatus,
    input wire logic [31:0] upsetFrameAddress,
    input wire logic [31:0] upsetNextFrameAddress,
    // Status
    output logic initComplete,
    output logic syncFound,
    output logic idPassed,
    output logic [4:0] lastCommand
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [31:0] dataS1_q, dataS2_q;
    logic validS1_q, validS2_q;
    logic [2:0] widthS1_q, widthS2_q;
    logic takeBeat;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dataS1_q <= '0;
            dataS2_q <= '0;
            validS1_q <= 1'b0;
            validS2_q <= 1'b0;
            widthS1_q <= '0;
            widthS2_q <= '0;
        end else begin
            dataS1_q <= busData;
            dataS2_q <= dataS1_q;
            validS1_q <= busValid && busReady;
            validS2_q <= validS1_q;
            widthS1_q <= busWidth;
            widthS2_q <= widthS1_q;
        end
    end

    // ------------------------------------------------------------
    // Word assembly
    // ------------------------------------------------------------
    logic [31:0] shift_q;
    logic [4:0] beat_q;
    logic [4:0] beatsPerWord;
    logic [31:0] shiftNext;
    logic wordDone;
    logic fifoInReady;
    logic syncHit;

    always_comb begin
        beatsPerWord = 5'h01;
        shiftNext = dataS2_q;
        case (cpp_pkg::cpp_width_t'(widthS2_q))
            cpp_pkg::CPP_W2: begin
                beatsPerWord = 5'h10;
                shiftNext = {shift_q[29:0], dataS2_q[1:0]};
            end
            cpp_pkg::CPP_W4: begin
                beatsPerWord = 5'h08;
                shiftNext = {shift_q[27:0], dataS2_q[3:0]};
            end
            cpp_pkg::CPP_W8: begin
                beatsPerWord = 5'h04;
                shiftNext = {shift_q[23:0], dataS2_q[7:0]};
            end
            cpp_pkg::CPP_W16: begin
                beatsPerWord = 5'h02;
                shiftNext = {shift_q[15:0], dataS2_q[15:0]};
            end
            default: begin
                beatsPerWord = 5'h01;
                shiftNext = dataS2_q;
            end
        endcase
    end

    // Ready is the FIFO's own ready; no early stall covers the two beats in the pipeline
    assign busReady = fifoInReady;
    assign takeBeat = validS2_q;
    assign wordDone = takeBeat && (beat_q + 5'h01 == beatsPerWord);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= '0;
            beat_q <= '0;
        end else if (takeBeat) begin
            shift_q <= shiftNext;
            beat_q <= (wordDone || syncHit) ? 5'h00 : beat_q + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // Sync hunt
    // ------------------------------------------------------------
    logic synced_q;
    logic fifoPush;

    // Before sync, alignment is unknown: slide the window each beat
    assign syncHit = !synced_q && takeBeat && (shiftNext == cpp_pkg::SYNC_WORD);
    assign fifoPush = synced_q && wordDone;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            synced_q <= 1'b0;
        end else if (syncHit) begin
            synced_q <= 1'b1;
        end
    end
    assign syncFound = synced_q;

    // ------------------------------------------------------------
    // Word FIFO
    // ------------------------------------------------------------
    logic wordValid;
    logic wordReady;
    logic [31:0] word;

    // No slots held back for beats in the synchronisers; ready drops only when all 16 are full
    cpp_fifo #(
        .WIDTH(cpp_pkg::WORD_W),
        .DEPTH(cpp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .inValid(fifoPush),
        .inReady(fifoInReady),
        .inData(shiftNext),
        .outValid(wordValid),
        .outReady(wordReady),
        .outData(word)
    );

    // ------------------------------------------------------------
    // Packet state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_HEADER,
        ST_DATA
    } cpp_state_t;

    cpp_state_t state_q;
    logic [26:0] count_q;
    logic [4:0] addr_q;
    logic [1:0] op_q;
    logic lastEmpty_q;
    logic ignore_q;
    logic [2:0] hdrType;
    logic [1:0] hdrOp;
    logic [4:0] hdrAddr;
    logic [26:0] hdrCount;
    logic isType1;
    logic isType2;
    logic hdrAccepted;
    logic hdrIgnore;
    logic dataWord;
    logic regWrite;
    logic regRead;
    logic idOk_q;
    logic [4:0] effAddr;

    assign wordReady = 1'b1;
    assign hdrType = word[cpp_pkg::HDR_TYPE_HI:cpp_pkg::HDR_TYPE_LO];
    assign hdrOp = word[cpp_pkg::HDR_OP_HI:cpp_pkg::HDR_OP_LO];
    assign isType1 = hdrType == cpp_pkg::HDR_TYPE1;
    assign isType2 = (hdrType == cpp_pkg::HDR_TYPE2) && lastEmpty_q;
    assign hdrAddr = isType1 ? word[cpp_pkg::HDR_ADDR_HI:cpp_pkg::HDR_ADDR_LO] : addr_q;
    assign hdrCount = isType1 ? {5'h00, word[cpp_pkg::HDR1_CNT_HI:0]} : word[cpp_pkg::HDR2_CNT_HI:0];
    assign hdrAccepted = wordValid && state_q == ST_HEADER && (isType1 || isType2);

    // Writes need a writable register, reads a readable one; the rest is dropped
    always_comb begin
        hdrIgnore = 1'b0;
        if (hdrOp == cpp_pkg::OP_WRITE) begin
            hdrIgnore = !cpp_pkg::REG_WRITABLE[hdrAddr];
        end else if (hdrOp == cpp_pkg::OP_READ) begin
            hdrIgnore = !cpp_pkg::REG_READABLE[hdrAddr];
        end else if (hdrOp != cpp_pkg::OP_NOP) begin
            hdrIgnore = 1'b1;
        end
        // Until identity passes only the identity, CRC and command are reachable
        if (!idOk_q && hdrAddr != cpp_pkg::REG_DEVICE_ID_CHECK && hdrAddr != cpp_pkg::REG_CRC_CHECK
            && hdrAddr != cpp_pkg::REG_COMMAND) begin
            hdrIgnore = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_HEADER;
            count_q <= '0;
            addr_q <= '0;
            op_q <= cpp_pkg::OP_NOP;
            lastEmpty_q <= 1'b0;
            ignore_q <= 1'b0;
        end else if (wordValid) begin
            case (state_q)
                ST_HEADER: begin
                    if (hdrAccepted) begin
                        addr_q <= hdrAddr;
                        op_q <= hdrOp;
                        ignore_q <= hdrIgnore;
                        count_q <= hdrCount;
                        lastEmpty_q <= isType1 && hdrCount == '0;
                        state_q <= (hdrCount == '0) ? ST_HEADER : ST_DATA;
                    end else begin
                        lastEmpty_q <= 1'b0;
                    end
                end
                ST_DATA: begin
                    count_q <= count_q - 27'h1;
                    if (count_q == 27'h1) begin
                        state_q <= ST_HEADER;
                    end
                end
                default: state_q <= ST_HEADER;
            endcase
        end
    end

    assign dataWord = wordValid && state_q == ST_DATA;
    assign effAddr = addr_q;
    assign regWrite = dataWord && !ignore_q && op_q == cpp_pkg::OP_WRITE;
    assign regRead = dataWord && !ignore_q && op_q == cpp_pkg::OP_READ;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [31:0] regs_q [32];
    logic [31:0] crc_q;
    logic [31:0] crcNext;
    logic done_q;
    logic clearCrc;

    // Every writable, storable register keeps the last word written
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_reg
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_q[gi] <= cpp_pkg::REG_RESET;
                end else if (regWrite && effAddr == 5'(gi) && cpp_pkg::REG_WRITABLE[gi]) begin
                    regs_q[gi] <= word;
                end
            end
        end
    endgenerate

    // Serial CRC over each accepted write data word; CRC-check writes and the clear command reset it
    always_comb begin
        crcNext = crc_q;
        for (int i = 31; i >= 0; i--) begin
            crcNext = {crcNext[30:0], 1'b0} ^ ((crcNext[31] ^ word[i]) ? cpp_pkg::CRC_POLY : 32'h0);
        end
    end

    assign clearCrc = regWrite && effAddr == cpp_pkg::REG_COMMAND
                      && word[4:0] == cpp_pkg::CMD_CLEAR_CRC;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            crc_q <= cpp_pkg::CRC_RESET;
        end else if (clearCrc || (regWrite && effAddr == cpp_pkg::REG_CRC_CHECK)) begin
            crc_q <= cpp_pkg::CRC_RESET;
        end else if (regWrite) begin
            crc_q <= crcNext;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b1;
            idOk_q <= 1'b0;
        end else if (regWrite) begin
            if (effAddr == cpp_pkg::REG_CRC_CHECK && word != crc_q) begin
                done_q <= 1'b0;
            end
            if (effAddr == cpp_pkg::REG_DEVICE_ID_CHECK) begin
                if (word[cpp_pkg::ID_CMP_BITS-1:0] == DEVICE_ID[cpp_pkg::ID_CMP_BITS-1:0]) begin
                    idOk_q <= 1'b1;
                end else begin
                    idOk_q <= 1'b0;
                    done_q <= 1'b0;
                end
            end
        end
    end

    assign initComplete = done_q;
    assign idPassed = idOk_q;
    assign lastCommand = regs_q[cpp_pkg::REG_COMMAND][4:0];

    // ------------------------------------------------------------
    // Readback and frame memory port
    // ------------------------------------------------------------
    logic [31:0] readMux;

    always_comb begin
        if (effAddr == cpp_pkg::REG_CRC_CHECK) begin
            readMux = crc_q;
        end else if (effAddr == cpp_pkg::REG_FRAME_DATA_OUT) begin
            readMux = frameDataOut;
        end else if (effAddr == cpp_pkg::REG_CONFIG_STATUS) begin
            readMux = configStatus;
        end else if (effAddr == cpp_pkg::REG_UPSET_STATUS) begin
            readMux = upsetStatus;
        end else if (effAddr == cpp_pkg::REG_HISTORY_STATUS) begin
            readMux = historyStatus;
        end else if (effAddr == cpp_pkg::REG_UPSET_FRAME_ADDRESS) begin
            readMux = upsetFrameAddress;
        end else if (effAddr == cpp_pkg::REG_UPSET_NEXT_FRAME_ADDRESS) begin
            readMux = upsetNextFrameAddress;
        end else begin
            readMux = regs_q[effAddr];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdValid <= 1'b0;
            rdData <= '0;
            memAccess <= '0;
        end else begin
            rdValid <= regRead;
            rdData <= regRead ? readMux : rdData;
            // Frame registers stream each word out for the memory engine
            memAccess.valid <= (regWrite || regRead)
                && (effAddr == cpp_pkg::REG_FRAME_DATA_IN || effAddr == cpp_pkg::REG_FRAME_DATA_OUT);
            memAccess.write <= regWrite;
            memAccess.addr <= effAddr;
            memAccess.data <= word;
        end
    end
endmodule

// ---- bench/cpp_parser_sva.sv ----
`timescale 1ns/10ps
module cpp_parser_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Watched outputs
    input wire logic rdValid,
    input wire logic [31:0] rdData,
    input wire cpp_pkg::cpp_access_t memAccess,
    input wire logic initComplete,
    input wire logic syncFound,
    input wire logic idPassed,
    input wire logic [4:0] lastCommand
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_done_sticky; !initComplete |=> !initComplete; endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag came back");
    property p_sync_sticky; syncFound |=> syncFound; endproperty
    a_sync_sticky: assert property (p_sync_sticky) else $error("sync lost");
    property p_mem_gate; memAccess.valid |-> idPassed && syncFound; endproperty
    a_mem_gate: assert property (p_mem_gate) else $error("frame write before id");
    property p_mem_target; memAccess.valid |-> memAccess.write && memAccess.addr == 5'h05; endproperty
    a_mem_target: assert property (p_mem_target) else $error("frame port target");
    property p_rd_gate; rdValid |-> idPassed; endproperty
    a_rd_gate: assert property (p_rd_gate) else $error("read before id");
    property p_rd_hold; !rdValid |-> $stable(rdData); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read word moved");
    property p_cmd_sync; $changed(lastCommand) |-> syncFound; endproperty
    a_cmd_sync: assert property (p_cmd_sync) else $error("command before sync");
    property p_fall_sync; $fell(initComplete) |-> syncFound; endproperty
    a_fall_sync: assert property (p_fall_sync) else $error("check before sync");
endmodule
bind cpp_parser cpp_parser_chk cpp_parser_chk_i (.mclk, .rst_n, .rdValid, .rdData,
    .memAccess, .initComplete, .syncFound, .idPassed, .lastCommand);

// ---- bench/cpp_source.sv ----
`timescale 1ns/10ps
module cpp_source (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Configuration data bus
    input wire cpp_pkg::cpp_width_t busWidth,
    output logic busValid,
    output logic [31:0] busData,
    input wire logic busReady
);
    logic [31:0] words [$];
    logic [31:0] cur;
    int beat, nb, bw;
    bit busy;
    function automatic bit idle();
        return words.size() == 0 && !busy;
    endfunction
    task automatic send(logic [31:0] w);
        words.push_back(w);
    endtask
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busValid <= 1'b0;
            busData <= 32'h0;
            busy = 0;
            beat = 0;
        end else begin
            nb = 16 >> busWidth;
            bw = 32 / nb;
            if (busValid && busReady) beat++;
            if (beat == nb) busy = 0;
            if (beat == nb) beat = 0;
            if (!busy && words.size() > 0) begin
                cur = words.pop_front();
                busy = 1;
            end
            // Random gaps; a refused beat is held as it was
            if (busy && ((busValid && !busReady) || $urandom_range(3) != 0)) begin
                busValid <= 1'b1;
                busData <= 32'((64'(cur) >> (32 - bw * (beat + 1))) & ((64'h1 << bw) - 1));
            end else begin
                busValid <= 1'b0;
                busData <= ~busData;
            end
        end
    end
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    localparam logic [31:0] DEV_ID = 32'h05a5a5a5; // Arbitrary value
    localparam logic [1:0] OPW = cpp_pkg::OP_WRITE;
    localparam logic [1:0] OPR = cpp_pkg::OP_READ;
    localparam logic [4:0] RA [5] = '{5'h09, 5'h0e, 5'h12, 5'h1d, 5'h1f};
    logic mclk, rst_n, busValid, busReady, rdValid, initComplete, syncFound, idPassed;
    logic [31:0] busData, rdData, v;
    logic [31:0] stat [6];
    logic [4:0] lastCommand;
    cpp_pkg::cpp_width_t busWidth;
    cpp_pkg::cpp_access_t memAccess;
    logic [37:0] expMem [$];
    logic [31:0] expRd [$];
    int fail_count, num_checks, i, n;
    cpp_source cpp_source_i (.mclk, .rst_n, .busWidth, .busValid, .busData, .busReady);
    cpp_parser #(.DEVICE_ID(DEV_ID)) cpp_parser_i (.mclk, .rst_n, .busWidth, .busValid,
        .busData, .busReady, .rdValid, .rdData, .memAccess, .frameDataOut(stat[0]),
        .configStatus(stat[1]), .upsetStatus(stat[2]), .historyStatus(stat[3]),
        .upsetFrameAddress(stat[4]), .upsetNextFrameAddress(stat[5]), .initComplete,
        .syncFound, .idPassed, .lastCommand);
    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [31:0] h1(logic [1:0] op, logic [4:0] a, int c);
        return {cpp_pkg::HDR_TYPE1, op, a, 22'(c)};
    endfunction
    // Header, then c random words; expected frame writes queued when e is set
    task automatic wr(logic [31:0] h, logic [4:0] a, int c, bit e);
        logic [31:0] d;
        cpp_source_i.send(h);
        repeat (c) begin
            d = $urandom;
            cpp_source_i.send(d);
            if (e) expMem.push_back({1'b1, a, d});
        end
    endtask
    // Source drained, then the documented pipeline latency plus margin
    task automatic settle();
        int k;
        for (k = 0; k < 3000 && !cpp_source_i.idle(); k++) @(posedge mclk);
        if (k == 3000) begin
            fail_count++;
            final_report();
        end
        repeat (8) @(posedge mclk);
    endtask
    task automatic do_reset(int w);
        rst_n <= 1'b0;
        busWidth <= cpp_pkg::cpp_width_t'(w);
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
    endtask
    always @(negedge mclk) begin
        if (rst_n && memAccess.valid === 1'b1) begin
            if (expMem.size() == 0) check("memExtra", 1, 0);
            else check("memAccess", {memAccess.write, memAccess.addr, memAccess.data}, expMem.pop_front());
        end
        if (rst_n && rdValid === 1'b1) begin
            if (expRd.size() == 0) check("rdExtra", 1, 0);
            else check("rdData", rdData, expRd.pop_front());
        end
    end
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        rst_n = 1'b0;
        busWidth = cpp_pkg::CPP_W2;
        void'($urandom(17827));
        for (i = 0; i < 6; i++) stat[i] = $urandom;
        for (n = 0; n < 5; n++) begin
            do_reset(n);
            wr(h1(OPW, 5'h01, 1), 0, 0, 0);
            cpp_source_i.send(DEV_ID);
            cpp_source_i.send(cpp_pkg::SYNC_WORD);
            wr(h1(OPW, 5'h05, 1), 5, 1, 0);
            wr(h1(OPR, 5'h09, 1), 0, 1, 0);
            settle();
            check("syncFound", syncFound, 1);
            check("idEarly", idPassed, 0);
            cpp_source_i.send(h1(OPW, 5'h01, 1));
            cpp_source_i.send({~DEV_ID[31:28], DEV_ID[27:0]});
            settle();
            check("idPassed", idPassed, 1);
            check("done", initComplete, 1);
        end
        wr(h1(OPW, 5'h05, 2), 5, 2, 1);
        wr(h1(OPW, 5'h05, 0), 5, 0, 0);
        wr({cpp_pkg::HDR_TYPE2, OPW, 27'd3}, 5, 3, 1);
        wr(h1(OPR, 5'h05, 1), 0, 1, 0);
        wr(h1(OPW, 5'h09, 1), 0, 1, 0);
        wr(h1(2'h3, 5'h05, 1), 0, 1, 0);
        wr(h1(OPW, 5'h13, 1), 0, 1, 0);
        wr(h1(OPW, 5'h05, 1), 5, 1, 1);
        foreach (RA[k]) begin
            wr(h1(OPR, RA[k], 1), 0, 1, 0);
            expRd.push_back(stat[k + 1]);
        end
        settle();
        check("memLeft", expMem.size(), 0);
        check("rdLeft", expRd.size(), 0);
        for (i = 1; i >= 0; i--) begin
            cpp_source_i.send(h1(OPW, 5'h02, 1));
            cpp_source_i.send(32'(i));
            settle();
            check("command", lastCommand, 5'(i));
        end
        wr(h1(OPW, 5'h00, 1), 0, 1, 0);
        settle();
        check("crcDone", initComplete, 0);
        do_reset(2);
        cpp_source_i.send(cpp_pkg::SYNC_WORD);
        cpp_source_i.send(h1(OPW, 5'h01, 1));
        cpp_source_i.send(DEV_ID ^ 32'h1);
        settle();
        check("idBad", {idPassed, initComplete}, 2'b00);
        // Long burst pushes the word buffer through the parser's own path
        do_reset(4);
        cpp_source_i.send(cpp_pkg::SYNC_WORD);
        cpp_source_i.send(h1(OPW, 5'h01, 1));
        cpp_source_i.send(DEV_ID);
        wr(h1(OPW, 5'h05, 20), 5, 20, 1);
        settle();
        check("fifoReady", busReady, 1);
        check("fifoLeft", expMem.size(), 0);
        check("fifoId", idPassed, 1);
        final_report();
    end
endmodule
